// ==== core/power_loss_ridethru_stall_guard.sv ====
// Power-loss ride-through sequencer and stall prevention with APB settings.
`timescale 1ns/10ps
`default_nettype none
`include "ridethru_stall_regs.svh"
module power_loss_ridethru_stall_guard #(
  parameter int unsigned MS_CYC = `MS_TICK_CYC
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [7:0]                  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic [31:0]                      prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        sample_valid,
  input  wire ridethru_stall_pkg::sample_t sample,
  input  wire logic                        run_cmd_pin,
  input  wire logic                        ctrl_power_ok_pin,
  input  wire logic                        accel_active,
  input  wire logic                        decel_active,
  input  wire logic                        const_speed,
  input  wire logic                        dcinj_stop_req,
  output logic                             undervoltage_alarm,
  output logic                             undervoltage_fault,
  output logic                             output_blocked,
  output logic                             speed_search,
  output logic [6:0]                       volt_ramp_pct,
  output logic                             accel_hold,
  output logic                             accel_stretch,
  output logic                             accel_fast,
  output logic                             decel_hold,
  output logic                             decel_fast,
  output logic                             run_stall_decel,
  output logic                             run_stall_use_decel_two,
  output logic                             dcinj_block,
  output logic                             dcinj_start
);
  import ridethru_stall_pkg::*;

  localparam cfg_t CFG_DEF = '{
    ridethru_select:            `RT_SEL_DEF,
    ridethru_time:              `RT_TIME_DEF,
    min_baseblock_time:         `BB_DEF,
    voltage_recovery_ramp_time: `RAMP_DEF,
    undervoltage_level:         `UV_LVL_DEF,
    input_voltage_setting:      `VIN_DEF,
    unit_480v:                  1'b0,
    accel_stall_select:         `ACC_SEL_DEF,
    accel_stall_level:          `ACC_LVL_DEF,
    decel_stall_select:         `DEC_SEL_DEF,
    run_stall_select:           `RUN_SEL_DEF,
    run_stall_level:            `RUN_LVL_DEF
  };

  // Limits a written setting to its legal range.
  function automatic logic [7:0] clamp8(input logic [7:0] v,
                                        input logic [7:0] lo,
                                        input logic [7:0] hi);
    clamp8 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp8

  // True when a percent value plus an offset reaches a level.
  function automatic logic near_lvl(input logic [7:0] a,
                                    input logic [7:0] lvl,
                                    input logic [7:0] off);
    near_lvl = ({1'b0, a} + {1'b0, off}) >= {1'b0, lvl};
  endfunction : near_lvl

  // Tells whether an address hits a register.
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `REG_RIDETHRU) || (a == `REG_TIMES) ||
             (a == `REG_LEVELS) || (a == `REG_STALL) ||
             (a == `REG_CTRL) || (a == `REG_STATUS);
  endfunction : mapped

  logic [1:0]  s1_ff, s2_ff, s3_ff, pin_ff;
  logic        ctrl_ok_d_ff;
  cfg_t        pend_ff, act_ff;
  logic [31:0] prdata_ff;
  logic        fault_clr_ff;
  sample_t     smp_ff;
  logic        uv_ff;
  logic [14:0] tick_cnt_ff;
  logic        tick;
  pl_state_t   state_ff, nxt_state;
  logic [14:0] tmr_ms_ff;
  logic [7:0]  ramp_div_ff;
  logic [6:0]  volt_ff;
  logic [14:0] rt_lim, bb_lim;
  logic        run_cmd, ctrl_ok;
  logic        acc_en, acc_over, dec_over;
  logic [9:0]  dec_lvl;
  logic [6:0]  run_ms_ff;
  logic        run_over;
  logic [14:0] dc_ms_ff;
  logic        acc_hold_ff, acc_str_ff, acc_fast_ff;
  logic        dec_hold_ff, dec_fast_ff, run_stall_ff, dc_blk_ff, dc_go_ff;
  logic        setup, access;
  logic [31:0] rd_word;

  // Three-stage pin synchronisers; a level counts once stages two and
  // three agree, which also rejects a single-cycle glitch.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_ff  <= 2'h0;
      s2_ff  <= 2'h0;
      s3_ff  <= 2'h0;
      pin_ff <= 2'h0;
    end else begin
      s1_ff <= {ctrl_power_ok_pin, run_cmd_pin};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      for (int i = 0; i < 2; i++) begin
        if (s2_ff[i] == s3_ff[i]) begin
          pin_ff[i] <= s3_ff[i];
        end
      end
    end
  end
  assign run_cmd = pin_ff[0];
  assign ctrl_ok = pin_ff[1];

  // APB handshake: zero wait states, error on unmapped addresses.
  assign setup   = psel & ~penable;
  assign access  = psel & penable;
  assign pready  = 1'b1;
  assign pslverr = access & ~mapped(paddr);
  assign prdata  = prdata_ff;

  // Pending settings written by software; clamped into range.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_ff      <= CFG_DEF;
      fault_clr_ff <= 1'b0;
    end else begin
      fault_clr_ff <= 1'b0;
      if (access && pwrite) begin
        case (paddr)
          `REG_RIDETHRU: begin
            // RULE24 selector encoding
            pend_ff.ridethru_select <=
              2'(clamp8({6'h0, pwdata[1:0]}, 8'h00, 8'h02));
            // RULE4 ride time range
            pend_ff.ridethru_time <= pwdata[15:8];
          end
          `REG_TIMES: begin
            // RULE8 baseblock range
            pend_ff.min_baseblock_time <=
              clamp8(pwdata[7:0], `BB_MIN, `BB_MAX);
            // RULE10 ramp time range
            pend_ff.voltage_recovery_ramp_time <=
              clamp8(pwdata[15:8], 8'h00, `RAMP_MAX);
          end
          `REG_LEVELS: begin
            // RULE11 undervoltage level range
            pend_ff.undervoltage_level <=
              clamp8(pwdata[7:0], `UV_LVL_MIN, `UV_LVL_MAX);
            pend_ff.input_voltage_setting <= pwdata[17:8];
            pend_ff.unit_480v             <= pwdata[24];
          end
          `REG_STALL: begin
            // RULE12 accel selector
            pend_ff.accel_stall_select <=
              2'(clamp8({6'h0, pwdata[1:0]}, 8'h00, 8'h02));
            // RULE18 decel selector
            pend_ff.decel_stall_select <= pwdata[3:2];
            // RULE22 run selector
            pend_ff.run_stall_select <=
              2'(clamp8({6'h0, pwdata[5:4]}, 8'h00, 8'h02));
            // RULE13 accel level range
            pend_ff.accel_stall_level <=
              clamp8(pwdata[15:8], 8'h00, `STALL_LVL_MAX);
            pend_ff.run_stall_level <=
              clamp8(pwdata[23:16], `RUN_LVL_MIN, `STALL_LVL_MAX);
          end
          `REG_CTRL: fault_clr_ff <= pwdata[0];
          default: ;
        endcase
      end
    end
  end

  // Read mux; status shows the live sequencer and stall state.
  always_comb begin
    rd_word = 32'h0;
    case (paddr)
      `REG_RIDETHRU: rd_word = {16'h0, pend_ff.ridethru_time,
                                6'h0, pend_ff.ridethru_select};
      `REG_TIMES:    rd_word = {16'h0, pend_ff.voltage_recovery_ramp_time,
                                pend_ff.min_baseblock_time};
      `REG_LEVELS:   rd_word = {7'h0, pend_ff.unit_480v, 6'h0,
                                pend_ff.input_voltage_setting,
                                pend_ff.undervoltage_level};
      `REG_STALL:    rd_word = {8'h0, pend_ff.run_stall_level,
                                pend_ff.accel_stall_level, 2'h0,
                                pend_ff.run_stall_select,
                                pend_ff.decel_stall_select,
                                pend_ff.accel_stall_select};
      `REG_STATUS:   rd_word = {12'h0, act_ff.ridethru_select, ctrl_ok,
                                run_cmd, volt_ff, run_stall_ff,
                                dec_hold_ff, acc_hold_ff, output_blocked,
                                undervoltage_fault, undervoltage_alarm,
                                state_ff};
      default:       rd_word = 32'h0;
    endcase
  end

  // Read data is captured in the setup cycle and held for the access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0;
    end else if (setup && !pwrite) begin
      prdata_ff <= rd_word;
    end
  end

  // RULE26 load at power-up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_ff       <= CFG_DEF;
      ctrl_ok_d_ff <= 1'b0;
    end else begin
      ctrl_ok_d_ff <= ctrl_ok;
      if (ctrl_ok && !ctrl_ok_d_ff) begin
        act_ff <= pend_ff;
      end
    end
  end

  // RULE25 latch each sample
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smp_ff <= '0;
      uv_ff  <= 1'b0;
    end else if (sample_valid) begin
      smp_ff <= sample;
      // RULE11 bus against level
      uv_ff  <= sample.dc_bus_v < {2'h0, act_ff.undervoltage_level};
    end
  end

  // Millisecond tick that paces every timer of the block.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_ff <= 15'h0;
    end else if (tick) begin
      tick_cnt_ff <= 15'h0;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 15'h1;
    end
  end
  assign tick = (tick_cnt_ff == 15'(MS_CYC - 1));

  assign rt_lim = 15'(act_ff.ridethru_time) * 15'(`MS_PER_DS);
  assign bb_lim = 15'(act_ff.min_baseblock_time) * 15'(`MS_PER_DS);

  // Power-loss sequencer next state.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      st_run: begin
        if (uv_ff) begin
          nxt_state = st_lost;
        end
      end
      st_lost: begin
        if (!ctrl_ok) begin
          nxt_state = st_fault;
        end else begin
          case (act_ff.ridethru_select)
            2'h0: begin
              // RULE1 fault after 15 ms
              if (tmr_ms_ff >= 15'(`UV_FAULT_MS / `TICK_MS)) begin
                nxt_state = st_fault;
              end else if (!uv_ff) begin
                nxt_state = st_run;
              end
            end
            2'h1: begin
              // RULE3 timed ride-through
              if (tmr_ms_ff >= rt_lim) begin
                nxt_state = st_fault;
              end else if (!uv_ff) begin
                // RULE7 run held through loss
                nxt_state = run_cmd ? st_block : st_run;
              end
            end
            default: begin
              // RULE6 ride while powered
              if (!uv_ff) begin
                nxt_state = run_cmd ? st_block : st_run;
              end
            end
          endcase
        end
      end
      st_block: begin
        // RULE8 baseblock before search
        if (uv_ff) begin
          nxt_state = st_lost;
        end else if (tmr_ms_ff >= bb_lim) begin
          nxt_state = st_search;
        end
      end
      st_search: begin
        if (uv_ff) begin
          nxt_state = st_lost;
        end else if (volt_ff == `RAMP_FULL) begin
          nxt_state = st_run;
        end
      end
      st_fault: begin
        // RULE2 restart needs reset, no run
        if (fault_clr_ff && !run_cmd) begin
          nxt_state = st_run;
        end
      end
      default: nxt_state = st_run;
    endcase
  end

  // State register and the millisecond timer that restarts per state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff  <= st_run;
      tmr_ms_ff <= 15'h0;
    end else begin
      state_ff <= nxt_state;
      if (nxt_state != state_ff) begin
        tmr_ms_ff <= 15'h0;
      end else if (tick && tmr_ms_ff != 15'h7fff) begin
        tmr_ms_ff <= tmr_ms_ff + 15'h1;
      end
    end
  end

  // RULE10 voltage recovery ramp
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      volt_ff     <= `RAMP_FULL;
      ramp_div_ff <= 8'h0;
    end else if (state_ff == st_run) begin
      volt_ff     <= `RAMP_FULL;
      ramp_div_ff <= 8'h0;
    end else if (state_ff != st_search) begin
      volt_ff     <= 7'h0;
      ramp_div_ff <= 8'h0;
    end else if (act_ff.voltage_recovery_ramp_time == 8'h0) begin
      volt_ff <= `RAMP_FULL;
    end else if (tick && volt_ff != `RAMP_FULL) begin
      if (ramp_div_ff + 8'h1 >= act_ff.voltage_recovery_ramp_time) begin
        ramp_div_ff <= 8'h0;
        volt_ff     <= volt_ff + 7'h1;
      end else begin
        ramp_div_ff <= ramp_div_ff + 8'h1;
      end
    end
  end

  // RULE5 alarm while lost
  assign undervoltage_alarm = (state_ff == st_lost);
  assign undervoltage_fault = (state_ff == st_fault);
  assign output_blocked     = (state_ff != st_run) &&
                              (state_ff != st_search) || dc_blk_ff;
  assign speed_search       = (state_ff == st_search);
  assign volt_ramp_pct      = volt_ff;

  // Stall comparisons on the held sample.
  // RULE17 no accel stall under 6 Hz
  assign acc_en   = accel_active && (act_ff.accel_stall_select != 2'h0) &&
                    (smp_ff.out_freq_dhz >= `ACC_MIN_FREQ);
  assign acc_over = smp_ff.out_current_pct > act_ff.accel_stall_level;
  // RULE20 decel bus level
  assign dec_lvl  = !act_ff.unit_480v ? `DEC_LVL_240 :
                    (act_ff.input_voltage_setting >= `VIN_SPLIT) ?
                    `DEC_LVL_480_HI : `DEC_LVL_480_LO;
  assign dec_over = smp_ff.dc_bus_v > dec_lvl;
  assign run_over = smp_ff.out_current_pct > act_ff.run_stall_level;

  // Acceleration and deceleration stall outputs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_hold_ff <= 1'b0;
      acc_str_ff  <= 1'b0;
      acc_fast_ff <= 1'b0;
      dec_hold_ff <= 1'b0;
      dec_fast_ff <= 1'b0;
    end else begin
      // RULE14 hold above level
      acc_hold_ff <= acc_en && acc_over;
      // RULE15 stretch in band
      acc_str_ff  <= acc_en && !acc_over &&
                     (act_ff.accel_stall_select == 2'h1) &&
                     near_lvl(smp_ff.out_current_pct,
                              act_ff.accel_stall_level, `ACC_BAND);
      // RULE16 intelligent accel
      acc_fast_ff <= acc_en && !acc_over &&
                     (act_ff.accel_stall_select == 2'h2);
      // RULE19 hold above bus level
      dec_hold_ff <= decel_active && dec_over &&
                     (act_ff.decel_stall_select != 2'h0);
      // RULE21 intelligent decel
      dec_fast_ff <= decel_active && !dec_over &&
                     (act_ff.decel_stall_select == 2'h2);
    end
  end

  // RULE23 run stall timing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_ms_ff    <= 7'h0;
      run_stall_ff <= 1'b0;
    end else if (act_ff.run_stall_select == 2'h0) begin
      run_ms_ff    <= 7'h0;
      run_stall_ff <= 1'b0;
    end else if (run_stall_ff) begin
      run_ms_ff <= 7'h0;
      if (!near_lvl(smp_ff.out_current_pct, act_ff.run_stall_level,
                    `RUN_HYST)) begin
        run_stall_ff <= 1'b0;
      end
    end else if (!(const_speed && run_over)) begin
      run_ms_ff <= 7'h0;
    end else if (run_ms_ff > 7'(`RUN_STALL_MS)) begin
      run_stall_ff <= 1'b1;
    end else if (tick) begin
      run_ms_ff <= run_ms_ff + 7'h1;
    end
  end
  assign run_stall_decel         = run_stall_ff;
  // RULE22 choose decel time
  assign run_stall_use_decel_two = (act_ff.run_stall_select == 2'h2);

  // RULE9 baseblock before injection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dc_blk_ff <= 1'b0;
      dc_go_ff  <= 1'b0;
      dc_ms_ff  <= 15'h0;
    end else begin
      dc_go_ff <= 1'b0;
      if (dcinj_stop_req && !dc_blk_ff) begin
        dc_blk_ff <= 1'b1;
        dc_ms_ff  <= 15'h0;
      end else if (dc_blk_ff && dc_ms_ff >= bb_lim) begin
        dc_blk_ff <= 1'b0;
        dc_go_ff  <= 1'b1;
      end else if (dc_blk_ff && tick) begin
        dc_ms_ff <= dc_ms_ff + 15'h1;
      end
    end
  end

  assign accel_hold    = acc_hold_ff;
  assign accel_stretch = acc_str_ff;
  assign accel_fast    = acc_fast_ff;
  assign decel_hold    = dec_hold_ff;
  assign decel_fast    = dec_fast_ff;
  assign dcinj_block   = dc_blk_ff;
  assign dcinj_start   = dc_go_ff;
endmodule : power_loss_ridethru_stall_guard
`default_nettype wire

// ==== core/ridethru_stall_regs.svh ====
// Register map, reset values and timing constants of the ride-through guard.
// Behaviour
// RULE1: Disabled mode: fault 15 ms after loss, no restart.
// RULE2: Disabled mode: restart needs run withdrawn, fault reset.
// RULE3: Timed mode: power back in time restarts cleanly.
// RULE4: Ride-through time spans 0.0 to 25.5 s.
// RULE5: Show undervoltage alarm while power is lost.
// RULE6: Control-power mode ignores time, restarts while powered.
// RULE7: Controller holds run command through power loss.
// RULE8: Baseblock 0.1 to 5.0 s before speed search.
// RULE9: Same baseblock before DC injection braking stop.
// RULE10: Search ramps voltage zero to maximum, 0-5 s.
// RULE11: Bus compared against 150-210 V, default 190.
// RULE12: Accel stall selector: off, general, intelligent.
// RULE13: Accel stall level 0-200 percent, default 120.
// RULE14: General accel stall holds speed above level.
// RULE15: Stretch acceleration within 15 percent of level.
// RULE16: Intelligent accel: fastest rate under current level.
// RULE17: No accel stall prevention below 6 Hz.
// RULE18: Decel selector: off, general, intelligent, resistor.
// RULE19: General decel stall holds speed above bus level.
// RULE20: Decel bus level 380, 760 or 660 V.
// RULE21: Intelligent decel: fastest rate under bus level.
// RULE22: Run stall selector: off, decel one, decel two.
// RULE23: Over run level 100 ms decelerates, 2 percent hysteresis.
// RULE24: Ride-through selector off, timed, control power; default 2.
// RULE25: Comparisons evaluated on each periodic sample.
// RULE26: Settings take effect only at power-up.
`ifndef RIDETHRU_STALL_REGS_SVH
`define RIDETHRU_STALL_REGS_SVH
`define REG_RIDETHRU   8'h00
`define REG_TIMES      8'h04
`define REG_LEVELS     8'h08
`define REG_STALL      8'h0c
`define REG_CTRL       8'h10
`define REG_STATUS     8'h14
`define RT_SEL_DEF     2'h2
`define RT_TIME_DEF    8'h14
`define BB_DEF         8'h05
`define BB_MIN         8'h01
`define BB_MAX         8'h32
`define RAMP_DEF       8'h03
`define RAMP_MAX       8'h32
`define UV_LVL_DEF     8'hbe
`define UV_LVL_MIN     8'h96
`define UV_LVL_MAX     8'hd2
`define VIN_DEF        10'h190
`define ACC_SEL_DEF    2'h1
`define ACC_LVL_DEF    8'h78
`define STALL_LVL_MAX  8'hc8
`define DEC_SEL_DEF    2'h1
`define RUN_SEL_DEF    2'h1
`define RUN_LVL_DEF    8'h78
`define RUN_LVL_MIN    8'h1e
`define DEC_LVL_240    10'h17c
`define DEC_LVL_480_HI 10'h2f8
`define DEC_LVL_480_LO 10'h294
`define VIN_SPLIT      10'h190
`define ACC_MIN_FREQ   12'h03c
`define ACC_BAND       8'h0f
`define RUN_HYST       8'h02
`define RAMP_FULL      7'h64
`define CLK_HZ         20000000
`define TICK_MS        1
`define MS_TICK_CYC    (`CLK_HZ / 1000 * `TICK_MS)
`define UV_FAULT_MS    15
`define RUN_STALL_MS   100
`define MS_PER_DS      7'h64
`endif

// ==== core/ridethru_stall_pkg.sv ====
// Types shared by the ride-through and stall guard.
package ridethru_stall_pkg;
  typedef enum logic [2:0] {
    st_run    = 3'h0,
    st_lost   = 3'h1,
    st_block  = 3'h3,
    st_search = 3'h2,
    st_fault  = 3'h6
  } pl_state_t;
  typedef struct packed {
    logic [9:0]  dc_bus_v;
    logic [7:0]  out_current_pct;
    logic [11:0] out_freq_dhz;
  } sample_t;
  typedef struct packed {
    logic [1:0] ridethru_select;
    logic [7:0] ridethru_time;
    logic [7:0] min_baseblock_time;
    logic [7:0] voltage_recovery_ramp_time;
    logic [7:0] undervoltage_level;
    logic [9:0] input_voltage_setting;
    logic       unit_480v;
    logic [1:0] accel_stall_select;
    logic [7:0] accel_stall_level;
    logic [1:0] decel_stall_select;
    logic [1:0] run_stall_select;
    logic [7:0] run_stall_level;
  } cfg_t;
endpackage : ridethru_stall_pkg

// ==== tb/guard_properties.sv ====
// Port-level checks for the ride-through and stall guard.
`timescale 1ns/10ps
`default_nettype none
module guard_properties #(
  parameter int unsigned MS_CYC = 20
) (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       run_cmd_pin,
  input wire logic       undervoltage_alarm,
  input wire logic       undervoltage_fault,
  input wire logic       output_blocked,
  input wire logic       speed_search,
  input wire logic [6:0] volt_ramp_pct,
  input wire logic       const_speed,
  input wire logic       run_stall_decel,
  input wire logic       dcinj_block,
  input wire logic       dcinj_start
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  int blk_ff;
  // Counts cycles of unbroken output blocking.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      blk_ff <= 0;
    else
      blk_ff <= output_blocked ? blk_ff + 1 : 0;
  end
  property p_excl; !(undervoltage_alarm && undervoltage_fault); endproperty
  a_excl: assert property (p_excl) else $error("alarm with fault");
  property p_src; $rose(undervoltage_fault) |-> $past(undervoltage_alarm);
  endproperty
  a_src: assert property (p_src) else $error("fault without loss");
  property p_hold;
    (run_cmd_pin [*8] ##0 undervoltage_fault) |=> undervoltage_fault;
  endproperty
  a_hold: assert property (p_hold) else $error("fault left");
  property p_bb; $rose(speed_search) |->
    $past(output_blocked) && blk_ff >= 500 * MS_CYC; endproperty
  a_bb: assert property (p_bb) else $error("short baseblock");
  property p_ramp; speed_search && $past(speed_search) &&
    $past(speed_search, 2) |-> volt_ramp_pct >= $past(volt_ramp_pct);
  endproperty
  a_ramp: assert property (p_ramp) else $error("ramp fell");
  property p_rmax; volt_ramp_pct <= 7'h64; endproperty
  a_rmax: assert property (p_rmax) else $error("ramp over full");
  property p_rs; $rose(run_stall_decel) |-> $past(const_speed); endproperty
  a_rs: assert property (p_rs) else $error("run stall off speed");
  property p_dci; $rose(dcinj_start) |-> $past(dcinj_block); endproperty
  a_dci: assert property (p_dci) else $error("start unblocked");
endmodule : guard_properties
`default_nettype wire

// ==== tb/supply_model.sv ====
// Power stage model that reports bus, current and frequency samples.
`timescale 1ns/10ps
`default_nettype none
module supply_model (
  input  wire logic                   pclk,
  input  wire logic [9:0]             bus_v,
  input  wire logic [7:0]             cur,
  input  wire logic [11:0]            freq,
  output var logic                    sample_valid = 1'b0,
  output var ridethru_stall_pkg::sample_t sample
);
  logic [2:0] tick_ff = 3'h0;
  always @(posedge pclk) begin
    tick_ff      <= tick_ff + 3'h1;
    sample_valid <= tick_ff == 3'h7;
    sample       <= {bus_v, cur, freq};
  end
endmodule : supply_model
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the ride-through and stall guard.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import ridethru_stall_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic        run_cmd_pin, ctrl_power_ok_pin, accel_active, decel_active;
  logic        const_speed, dcinj_stop_req, sample_valid, dcinj_block;
  logic        undervoltage_alarm, undervoltage_fault, output_blocked;
  logic        speed_search, accel_hold, decel_hold, run_stall_decel;
  logic        run_stall_use_decel_two, dcinj_start;
  logic [6:0]  volt_ramp_pct;
  logic [7:0]  paddr, cur;
  logic [9:0]  bus_v;
  logic [11:0] freq;
  logic [31:0] pwdata, prdata, rd;
  sample_t     sample;
  int          mismatches = 0;
  int          compares = 0;
  logic [7:0]  ad [4] = '{8'h00, 8'h04, 8'h08, 8'h0c};
  logic [31:0] ex [4] = '{32'h1402, 32'h0305, 32'h190be, 32'h787815};
  power_loss_ridethru_stall_guard #(.MS_CYC(20)) dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .sample_valid, .sample, .run_cmd_pin,
    .ctrl_power_ok_pin, .accel_active, .decel_active, .const_speed,
    .dcinj_stop_req, .undervoltage_alarm, .undervoltage_fault,
    .output_blocked, .speed_search, .volt_ramp_pct, .accel_hold,
    .accel_stretch(), .accel_fast(), .decel_hold, .decel_fast(),
    .run_stall_decel, .run_stall_use_decel_two, .dcinj_block, .dcinj_start
  );
  supply_model plant (.pclk, .bus_v, .cur, .freq, .sample_valid, .sample);
  task automatic give_verdict;
    if (mismatches == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  task automatic abort_run;
    mismatches++;
    give_verdict();
  endtask : abort_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic ms(input int n);
    repeat (n * 20) @(posedge pclk);
  endtask : ms
  task automatic wait_for(ref logic s, input logic v, input int n);
    for (int i = 0; i < n && s !== v; i++)
      @(posedge pclk);
    if (s !== v)
      abort_run();
  endtask : wait_for
  // One APB transfer; keeps read data and the error flag.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
    repeat (2) @(posedge pclk);
    if (i == 16)
      abort_run();
  endtask : apb
  initial begin
    pclk = 1'b0;
    forever
      #25 pclk = ~pclk;
  end
  // Reset, register map, stall checks, then the control-power and disabled power loss modes.
  initial begin
    {presetn, psel, penable, pwrite, accel_active, decel_active} = '0;
    {const_speed, dcinj_stop_req, paddr, pwdata, cur, freq} = '0;
    {run_cmd_pin, ctrl_power_ok_pin, bus_v} = {2'b11, 10'h136};
    void'($urandom(61832));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, 8'h14, 0);
    chk({rd[19:18], rd[15:0]}, 18'h2c800);
    foreach (ad[k]) begin
      apb(0, ad[k], 0);
      chk(rd, ex[k]);
    end
    apb(0, 8'h40, 0);
    chk(er, 1'b1);
    apb(1, 8'h00, 32'hff03);
    apb(1, 8'h08, 32'h19050);
    apb(0, 8'h00, 0);
    chk(rd, 32'hff02);
    apb(0, 8'h08, 0);
    chk(rd, 32'h19096);
    apb(1, 8'h08, 32'h190be);
    for (int k = 0; k < 24; k++) begin
      accel_active <= k[0];
      decel_active <= !k[0];
      cur <= 8'($urandom_range(200, 60));
      freq <= 12'($urandom_range(120, 0));
      bus_v <= 10'($urandom_range(460, 300));
      repeat (24) @(posedge pclk);
      chk(accel_hold, k[0] && freq >= 60 && cur > 120);
      chk(decel_hold, !k[0] && bus_v > 380);
    end
    {accel_active, decel_active, const_speed} <= 3'b001;
    {cur, bus_v} <= {8'h82, 10'h136};
    ms(95);
    chk(run_stall_decel, 1'b0);
    ms(10);
    chk(run_stall_decel, 1'b1);
    chk(run_stall_use_decel_two, 1'b0);
    cur <= 8'h76;
    ms(2);
    chk(run_stall_decel, 1'b1);
    cur <= 8'h75;
    ms(2);
    chk(run_stall_decel, 1'b0);
    {const_speed, bus_v} <= {1'b0, 10'hbe};
    ms(2);
    chk(undervoltage_alarm, 1'b0);
    bus_v <= 10'hbd;
    ms(2);
    chk(undervoltage_alarm, 1'b1);
    ms(40);
    chk(undervoltage_fault, 1'b0);
    bus_v <= 10'h136;
    ms(2);
    chk(output_blocked, 1'b1);
    wait_for(speed_search, 1'b1, 10400);
    wait_for(speed_search, 1'b0, 6200);
    chk(volt_ramp_pct, 7'h64);
    apb(1, 8'h00, 32'h1400);
    ctrl_power_ok_pin <= 1'b0;
    ms(1);
    ctrl_power_ok_pin <= 1'b1;
    ms(1);
    bus_v <= 10'h64;
    ms(14);
    chk(undervoltage_fault, 1'b0);
    ms(3);
    chk(undervoltage_fault, 1'b1);
    bus_v <= 10'h136;
    ms(5);
    apb(1, 8'h10, 1);
    chk(undervoltage_fault, 1'b1);
    run_cmd_pin <= 1'b0;
    ms(1);
    apb(1, 8'h10, 1);
    chk(undervoltage_fault, 1'b0);
    dcinj_stop_req <= 1'b1;
    @(posedge pclk);
    dcinj_stop_req <= 1'b0;
    ms(490);
    chk(dcinj_block, 1'b1);
    wait_for(dcinj_start, 1'b1, 400);
    give_verdict();
  end
endmodule : testbench
bind power_loss_ridethru_stall_guard guard_properties #(.MS_CYC(MS_CYC))
  props (.pclk, .presetn, .run_cmd_pin, .undervoltage_alarm,
    .undervoltage_fault, .output_blocked, .speed_search, .volt_ramp_pct,
    .const_speed, .run_stall_decel, .dcinj_block, .dcinj_start);
`default_nettype wire
